// ==== design/egpm_regs.svh ====
// Register offsets, field positions, reset values and counts for the
// shared memory-bus / port pin block.
// Assumes an APB slave with 32-bit data and byte addresses.
//
// Summary of operation
// - Port B pin zero: software GPIO input or output
// - Idle top address line and strobes follow drive bit
// - Reset function of pin zero from boot straps
// - Peripheral-enable write always overrides the strap choice
// - Clearing port B pull-up bit 0 disables pull-up
// - Seven low data pins carry memory data
// - Idle data pins driven or floated per drive bit
// - Each shared port F pin individually input/output
// - Port F shared pins reset to data bus
// - Port F pull-up bits, lowest pin bit 9

`ifndef EGPM_REGS_SVH
`define EGPM_REGS_SVH

// Byte offsets
`define EGPM_BUS_CONTROL_OFF 8'h00
`define EGPM_PB_PERIPH_OFF 8'h04
`define EGPM_PB_DIR_OFF 8'h08
`define EGPM_PB_DATA_OFF 8'h0c
`define EGPM_PB_PULLUP_OFF 8'h10
`define EGPM_PB_PIN_OFF 8'h14
`define EGPM_PF_PERIPH_OFF 8'h18
`define EGPM_PF_DIR_OFF 8'h1c
`define EGPM_PF_DATA_OFF 8'h20
`define EGPM_PF_PULLUP_OFF 8'h24
`define EGPM_PF_PIN_OFF 8'h28
`define EGPM_STATUS_OFF 8'h2c

// Field positions
`define EGPM_DRIVE_BIT 0
`define EGPM_PB_BIT 0
`define EGPM_PF_LSB 9
`define EGPM_PF_MSB 15
`define EGPM_ST_STRAP_ADDR 0
`define EGPM_ST_STRAP_DONE 1
`define EGPM_ST_BUS_ACTIVE 2

// Reset values
`define EGPM_BUS_CONTROL_RST 1'b0
`define EGPM_PB_PULLUP_RST 1'b1
`define EGPM_PF_PERIPH_RST 7'h7f
`define EGPM_PF_PULLUP_RST 7'h7f

// Cycles the strap synchronisers need before the straps are trusted
`define EGPM_STRAP_SETTLE 2'h3

`endif

// ==== design/egpm_pkg.sv ====
// Types for the shared memory-bus / port pin block.
// Assumes nothing of its surroundings.
package egpm_pkg;

  // Phases of the start-up strap capture
  typedef enum logic [1:0] {
    EGPM_STRAP_WAIT,
    EGPM_STRAP_LOAD,
    EGPM_STRAP_DONE
  } egpm_strap_state_t;

endpackage

// ==== design/egpm_pin_cell.sv ====
// Output mux and input synchroniser for a group of shared pins.
// Assumes select, direction and data come from pclk logic; pin_in is
// asynchronous and is synchronised here.
module egpm_pin_cell #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] periph_sel,
  input wire logic [W-1:0] gpio_dir,
  input wire logic [W-1:0] gpio_dout,
  input wire logic [W-1:0] emi_dout,
  input wire logic [W-1:0] emi_drive,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] out_d;
  logic [W-1:0] oe_n_d;
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Peripheral selects memory bus, otherwise port direction/data
  assign out_d = (periph_sel & emi_dout) | (~periph_sel & gpio_dout);
  assign oe_n_d = ~((periph_sel & emi_drive) | (~periph_sel & gpio_dir));

  // Outputs registered; floated during reset so pull-ups hold the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= out_d;
      pin_oe_n <= oe_n_d;
    end
  end

  // Two-stage synchroniser; only sync_q is read downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

// ==== design/egpm_pin_mux.sv ====
// Shared pin logic: top address line on port B pin zero, data lines
// zero to six on port F pins nine to fifteen, plus the idle drive of
// the read and write strobes. Registers reached over APB.
// Assumes the memory interface runs on pclk; pins and straps are
// asynchronous and pass two flip-flops before use.
`include "egpm_regs.svh"

module egpm_pin_mux #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot straps
  input wire logic external_boot_input,
  input wire logic memory_interface_mode_input,
  input wire logic flash_secure_input,
  // Memory interface side
  input wire logic emi_bus_active,
  input wire logic top_address_line,
  input wire logic [6:0] emi_data_out,
  input wire logic emi_data_write,
  input wire logic emi_read_strobe_n,
  input wire logic emi_write_strobe_n,
  output logic [6:0] emi_data_in,
  // Port B pin zero
  input wire logic port_b_pin_zero_in,
  output logic port_b_pin_zero_out,
  output logic port_b_pin_zero_oe_n,
  output logic port_b_pin_zero_pullup,
  // Data line zero to six, port F pins nine to fifteen
  input wire logic [6:0] port_f_pin_in,
  output logic [6:0] port_f_pin_out,
  output logic [6:0] port_f_pin_oe_n,
  output logic [6:0] port_f_pin_pullup,
  // Read and write strobes
  output logic read_strobe_n_out,
  output logic read_strobe_n_oe_n,
  output logic write_strobe_n_out,
  output logic write_strobe_n_oe_n
);

  // Register state
  logic bus_drive_select_q;
  logic port_b_peripheral_enable_q;
  logic port_b_peripheral_enable_d;
  logic pb_per_written_q;
  logic pb_dir_q;
  logic pb_data_q;
  logic port_b_pullup_enable_q;
  logic [6:0] pf_per_q;
  logic [6:0] pf_dir_q;
  logic [6:0] pf_data_q;
  logic [6:0] port_f_pullup_enable_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Strap synchronisers and capture
  logic [2:0] strap_meta_q;
  logic [2:0] strap_sync_q;
  logic strap_addr;
  logic strap_addr_q;
  logic [1:0] strap_cnt_q;
  egpm_pkg::egpm_strap_state_t strap_state_q;
  egpm_pkg::egpm_strap_state_t strap_state_d;
  logic strap_load;

  // Pin side
  logic pb_sync;
  logic [6:0] pf_sync;
  logic addr_drive;
  logic [6:0] data_drive;
  logic strobe_drive;

  // Offset match, used by every register decode
  function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [7:0] off);
    reg_hit = (addr == AW'(off));
  endfunction

  // APB phase decode
  logic setup_ph;
  logic wr_acc;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // Register selects
  logic hit_bcr;
  logic hit_pb_per;
  logic hit_pb_dir;
  logic hit_pb_data;
  logic hit_pb_pur;
  logic hit_pb_pin;
  logic hit_pf_per;
  logic hit_pf_dir;
  logic hit_pf_data;
  logic hit_pf_pur;
  logic hit_pf_pin;
  logic hit_status;
  logic hit_any;
  assign hit_bcr = reg_hit(paddr, `EGPM_BUS_CONTROL_OFF);
  assign hit_pb_per = reg_hit(paddr, `EGPM_PB_PERIPH_OFF);
  assign hit_pb_dir = reg_hit(paddr, `EGPM_PB_DIR_OFF);
  assign hit_pb_data = reg_hit(paddr, `EGPM_PB_DATA_OFF);
  assign hit_pb_pur = reg_hit(paddr, `EGPM_PB_PULLUP_OFF);
  assign hit_pb_pin = reg_hit(paddr, `EGPM_PB_PIN_OFF);
  assign hit_pf_per = reg_hit(paddr, `EGPM_PF_PERIPH_OFF);
  assign hit_pf_dir = reg_hit(paddr, `EGPM_PF_DIR_OFF);
  assign hit_pf_data = reg_hit(paddr, `EGPM_PF_DATA_OFF);
  assign hit_pf_pur = reg_hit(paddr, `EGPM_PF_PULLUP_OFF);
  assign hit_pf_pin = reg_hit(paddr, `EGPM_PF_PIN_OFF);
  assign hit_status = reg_hit(paddr, `EGPM_STATUS_OFF);
  assign hit_any = hit_bcr | hit_pb_per | hit_pb_dir | hit_pb_data | hit_pb_pur
                 | hit_pb_pin | hit_pf_per | hit_pf_dir | hit_pf_data | hit_pf_pur
                 | hit_pf_pin | hit_status;

  // Write strobes, taken only on the access-phase edge
  logic wr_bcr;
  logic wr_pb_per;
  logic wr_pb_dir;
  logic wr_pb_data;
  logic wr_pb_pur;
  logic wr_pf_per;
  logic wr_pf_dir;
  logic wr_pf_data;
  logic wr_pf_pur;
  assign wr_bcr = wr_acc && hit_bcr;
  assign wr_pb_per = wr_acc && hit_pb_per;
  assign wr_pb_dir = wr_acc && hit_pb_dir;
  assign wr_pb_data = wr_acc && hit_pb_data;
  assign wr_pb_pur = wr_acc && hit_pb_pur;
  assign wr_pf_per = wr_acc && hit_pf_per;
  assign wr_pf_dir = wr_acc && hit_pf_dir;
  assign wr_pf_data = wr_acc && hit_pf_data;
  assign wr_pf_pur = wr_acc && hit_pf_pur;

  // Port F fields sit in bits nine to fifteen of their registers
  logic [6:0] wr_pf_field;
  assign wr_pf_field = pwdata[`EGPM_PF_MSB:`EGPM_PF_LSB];

  // Read mux, prepared in the setup phase so prdata comes from a flop
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  assign status_word = {29'h0, emi_bus_active,
                        strap_state_q == egpm_pkg::EGPM_STRAP_DONE, strap_addr_q};
  assign rd_mux = hit_bcr ? {31'h0, bus_drive_select_q} :
                  hit_pb_per ? {31'h0, port_b_peripheral_enable_q} :
                  hit_pb_dir ? {31'h0, pb_dir_q} :
                  hit_pb_data ? {31'h0, pb_data_q} :
                  hit_pb_pur ? {31'h0, port_b_pullup_enable_q} :
                  hit_pb_pin ? {31'h0, pb_sync} :
                  hit_pf_per ? {16'h0, pf_per_q, 9'h0} :
                  hit_pf_dir ? {16'h0, pf_dir_q, 9'h0} :
                  hit_pf_data ? {16'h0, pf_data_q, 9'h0} :
                  hit_pf_pur ? {16'h0, port_f_pullup_enable_q, 9'h0} :
                  hit_pf_pin ? {16'h0, pf_sync, 9'h0} :
                  hit_status ? status_word :
                  32'h0;

  // Read data and error latched in setup; answer is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  // Bus control: drive bit resets to float; software is expected to set it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_drive_select_q <= `EGPM_BUS_CONTROL_RST;
    end else if (wr_bcr) begin
      bus_drive_select_q <= pwdata[`EGPM_DRIVE_BIT];
    end
  end

  // Straps come from pins: two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_q <= 3'h0;
      strap_sync_q <= 3'h0;
    end else begin
      strap_meta_q <= {flash_secure_input, memory_interface_mode_input,
                       external_boot_input};
      strap_sync_q <= strap_meta_q;
    end
  end

  // Address function at start-up: external boot, or memory mode while
  // the flash is not secured
  assign strap_addr = strap_sync_q[0] | (strap_sync_q[1] & ~strap_sync_q[2]);

  // Strap capture sequencer; waits for the synchronisers to fill
  always_comb begin
    strap_state_d = strap_state_q;
    unique case (strap_state_q)
      egpm_pkg::EGPM_STRAP_WAIT: begin
        if (strap_cnt_q == `EGPM_STRAP_SETTLE) begin
          strap_state_d = egpm_pkg::EGPM_STRAP_LOAD;
        end
      end
      egpm_pkg::EGPM_STRAP_LOAD: begin
        strap_state_d = egpm_pkg::EGPM_STRAP_DONE;
      end
      egpm_pkg::EGPM_STRAP_DONE: begin
        strap_state_d = egpm_pkg::EGPM_STRAP_DONE;
      end
      default: begin
        strap_state_d = egpm_pkg::EGPM_STRAP_WAIT;
      end
    endcase
  end

  assign strap_load = strap_state_q == egpm_pkg::EGPM_STRAP_LOAD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_state_q <= egpm_pkg::EGPM_STRAP_WAIT;
      strap_cnt_q <= 2'h0;
    end else begin
      strap_state_q <= strap_state_d;
      if (strap_state_q == egpm_pkg::EGPM_STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // Strap result kept for status; caught by a clock edge, not by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_addr_q <= 1'b0;
    end else if (strap_load) begin
      strap_addr_q <= strap_addr;
    end
  end

  // A software write always wins; an early write also blocks the strap
  // load so the user's choice is never overwritten afterwards
  assign port_b_peripheral_enable_d =
    wr_pb_per ? pwdata[`EGPM_PB_BIT] :
    (strap_load && !pb_per_written_q) ? strap_addr :
    port_b_peripheral_enable_q;

  // Pin is a port input until the straps are known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_peripheral_enable_q <= 1'b0;
      pb_per_written_q <= 1'b0;
    end else begin
      port_b_peripheral_enable_q <= port_b_peripheral_enable_d;
      if (wr_pb_per) begin
        pb_per_written_q <= 1'b1;
      end
    end
  end

  // Port B direction, data and pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_dir_q <= 1'b0;
      pb_data_q <= 1'b0;
      port_b_pullup_enable_q <= `EGPM_PB_PULLUP_RST;
    end else begin
      if (wr_pb_dir) begin
        pb_dir_q <= pwdata[`EGPM_PB_BIT];
      end
      if (wr_pb_data) begin
        pb_data_q <= pwdata[`EGPM_PB_BIT];
      end
      if (wr_pb_pur) begin
        port_b_pullup_enable_q <= pwdata[`EGPM_PB_BIT];
      end
    end
  end

  // Port F select, direction, data and pull-ups; bus function at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_per_q <= `EGPM_PF_PERIPH_RST;
      pf_dir_q <= 7'h0;
      pf_data_q <= 7'h0;
      port_f_pullup_enable_q <= `EGPM_PF_PULLUP_RST;
    end else begin
      if (wr_pf_per) begin
        pf_per_q <= wr_pf_field;
      end
      if (wr_pf_dir) begin
        pf_dir_q <= wr_pf_field;
      end
      if (wr_pf_data) begin
        pf_data_q <= wr_pf_field;
      end
      if (wr_pf_pur) begin
        port_f_pullup_enable_q <= wr_pf_field;
      end
    end
  end

  // Pull-up controls go straight out of their registers
  assign port_b_pin_zero_pullup = port_b_pullup_enable_q;
  assign port_f_pin_pullup = port_f_pullup_enable_q;

  // Address and strobes drive during a cycle; when idle the drive bit
  // decides whether they hold their level or float
  assign addr_drive = emi_bus_active | bus_drive_select_q;
  assign strobe_drive = emi_bus_active | bus_drive_select_q;

  // Data drives only for writes in a cycle; floats on reads so the
  // memory can answer; idle follows the drive bit
  assign data_drive = {7{emi_bus_active ? emi_data_write : bus_drive_select_q}};

  egpm_pin_cell #(
    .W(1)
  ) u_port_b (
    .pclk(pclk),
    .presetn(presetn),
    .periph_sel(port_b_peripheral_enable_q),
    .gpio_dir(pb_dir_q),
    .gpio_dout(pb_data_q),
    .emi_dout(top_address_line),
    .emi_drive(addr_drive),
    .pin_in(port_b_pin_zero_in),
    .pin_out(port_b_pin_zero_out),
    .pin_oe_n(port_b_pin_zero_oe_n),
    .pin_sync(pb_sync)
  );

  egpm_pin_cell #(
    .W(7)
  ) u_port_f (
    .pclk(pclk),
    .presetn(presetn),
    .periph_sel(pf_per_q),
    .gpio_dir(pf_dir_q),
    .gpio_dout(pf_data_q),
    .emi_dout(emi_data_out),
    .emi_drive(data_drive),
    .pin_in(port_f_pin_in),
    .pin_out(port_f_pin_out),
    .pin_oe_n(port_f_pin_oe_n),
    .pin_sync(pf_sync)
  );

  // Read data back to the memory interface, zero where a pin is GPIO
  assign emi_data_in = pf_sync & pf_per_q;

  // Strobes registered like the shared pins to keep skew matched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_strobe_n_out <= 1'b1;
      read_strobe_n_oe_n <= 1'b1;
      write_strobe_n_out <= 1'b1;
      write_strobe_n_oe_n <= 1'b1;
    end else begin
      read_strobe_n_out <= emi_read_strobe_n;
      read_strobe_n_oe_n <= !strobe_drive;
      write_strobe_n_out <= emi_write_strobe_n;
      write_strobe_n_oe_n <= !strobe_drive;
    end
  end

endmodule

// ==== verification/egpm_mem_model.sv ====
// External memory on the seven low data lines.
// Assumes the device's pin outputs and enables; it resolves each wire.
module egpm_mem_model (
  input wire logic pclk,
  input wire logic read_strobe_n_out,
  input wire logic read_strobe_n_oe_n,
  input wire logic [6:0] port_f_pin_out,
  input wire logic [6:0] port_f_pin_oe_n,
  input wire logic [6:0] port_f_pin_pullup,
  input wire logic [6:0] mem_word,
  output logic [6:0] port_f_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] last_q = 7'h00;
  // Memory answers only while the device asserts the read strobe
  wire rd_on = !read_strobe_n_oe_n && !read_strobe_n_out;
  // Device first, then memory, then pull-up; a floating line toggles
  // so that a stale value never looks valid
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!port_f_pin_oe_n[i]) port_f_pin_in[i] = port_f_pin_out[i];
      else if (rd_on) port_f_pin_in[i] = mem_word[i];
      else if (port_f_pin_pullup[i]) port_f_pin_in[i] = 1'b1;
      else port_f_pin_in[i] = ~last_q[i];
    end
  end
  // Remember last level for the floating case
  always_ff @(posedge pclk) last_q <= port_f_pin_in;
endmodule

// ==== verification/egpm_pin_mux_checker.sv ====
// Port assertions for the shared pin mux.
// Assumes it is bound to egpm_pin_mux; registers are shadowed from APB writes.
`include "egpm_regs.svh"
module egpm_pin_mux_checker #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic emi_bus_active,
  input wire logic top_address_line,
  input wire logic [6:0] emi_data_out,
  input wire logic emi_data_write,
  input wire logic [6:0] emi_data_in,
  input wire logic port_b_pin_zero_out,
  input wire logic port_b_pin_zero_oe_n,
  input wire logic port_b_pin_zero_pullup,
  input wire logic [6:0] port_f_pin_out,
  input wire logic [6:0] port_f_pin_oe_n,
  input wire logic [6:0] port_f_pin_pullup,
  input wire logic read_strobe_n_oe_n,
  input wire logic write_strobe_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic drive_q, pb_per_q, pb_wr_q, pb_dir_q, pb_dat_q, pb_pu_q;
  logic [6:0] pf_per_q, pf_dir_q, pf_dat_q, pf_pu_q;
  // Shadow registers; port B function is trusted only once software wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {drive_q, pb_per_q, pb_wr_q, pb_dir_q, pb_dat_q, pb_pu_q} <= 6'h01;
      {pf_per_q, pf_dir_q, pf_dat_q, pf_pu_q} <= {7'h7f, 7'h00, 7'h00, 7'h7f};
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `EGPM_BUS_CONTROL_OFF: drive_q <= pwdata[0];
        `EGPM_PB_PERIPH_OFF: {pb_wr_q, pb_per_q} <= {1'b1, pwdata[0]};
        `EGPM_PB_DIR_OFF: pb_dir_q <= pwdata[0];
        `EGPM_PB_DATA_OFF: pb_dat_q <= pwdata[0];
        `EGPM_PB_PULLUP_OFF: pb_pu_q <= pwdata[0];
        `EGPM_PF_PERIPH_OFF: pf_per_q <= pwdata[15:9];
        `EGPM_PF_DIR_OFF: pf_dir_q <= pwdata[15:9];
        `EGPM_PF_DATA_OFF: pf_dat_q <= pwdata[15:9];
        `EGPM_PF_PULLUP_OFF: pf_pu_q <= pwdata[15:9];
        default: ;
      endcase
    end
  end
  // Expected drive of bus-function pins
  wire strobe_drv = emi_bus_active || drive_q;
  wire data_drv = emi_bus_active ? emi_data_write : drive_q;
  wire [6:0] f_oe_n = ~((pf_per_q & {7{data_drv}}) | (~pf_per_q & pf_dir_q));
  wire [6:0] f_out = (pf_per_q & emi_data_out) | (~pf_per_q & pf_dat_q);

  rd_strobe_drive_a: assert property (read_strobe_n_oe_n == !$past(strobe_drv))
    else $error("read strobe enable wrong");
  wr_strobe_drive_a: assert property (strobe_drv |=> !write_strobe_n_oe_n)
    else $error("write strobe not driven");
  data_enable_a: assert property (port_f_pin_oe_n == $past(f_oe_n))
    else $error("data pin enable wrong");
  data_value_a: assert property (emi_bus_active && emi_data_write |=>
    ((port_f_pin_out ^ $past(f_out)) & ~port_f_pin_oe_n) == 7'h00)
    else $error("data pin value wrong");
  data_in_mask_a: assert property ((emi_data_in & ~pf_per_q) == 7'h00)
    else $error("gpio pin leaks to bus");
  pf_pullup_a: assert property (port_f_pin_pullup == pf_pu_q)
    else $error("port f pull-up wrong");
  pb_pullup_a: assert property (port_b_pin_zero_pullup == pb_pu_q)
    else $error("port b pull-up wrong");
  pb_gpio_dir_a: assert property ($past(pb_wr_q) && !$past(pb_per_q) |->
    port_b_pin_zero_oe_n == !$past(pb_dir_q))
    else $error("port b direction wrong");
  pb_gpio_out_a: assert property ($past(pb_wr_q) && !$past(pb_per_q) && $past(pb_dir_q) |->
    port_b_pin_zero_out == $past(pb_dat_q))
    else $error("port b data wrong");
  pb_addr_drive_a: assert property ($past(pb_wr_q) && $past(pb_per_q) |->
    port_b_pin_zero_oe_n == !$past(strobe_drv))
    else $error("address pin enable wrong");
  pb_addr_value_a: assert property ($past(pb_wr_q) && $past(pb_per_q) &&
    $past(emi_bus_active) |-> port_b_pin_zero_out == $past(top_address_line))
    else $error("address pin value wrong");
endmodule

bind egpm_pin_mux egpm_pin_mux_checker #(.AW(AW)) i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .emi_bus_active, .top_address_line, .emi_data_out,
  .emi_data_write, .emi_data_in, .port_b_pin_zero_out, .port_b_pin_zero_oe_n,
  .port_b_pin_zero_pullup, .port_f_pin_out, .port_f_pin_oe_n, .port_f_pin_pullup,
  .read_strobe_n_oe_n, .write_strobe_n_oe_n);

// ==== verification/egpm_pin_mux_test.sv ====
// Self-checking bench for the shared pin mux.
// Assumes the memory model on port F; the checker binds itself.
`include "egpm_regs.svh"
module egpm_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  logic external_boot_input = 1'b0, memory_interface_mode_input = 1'b0;
  logic flash_secure_input = 1'b0, emi_bus_active = 1'b0, top_address_line = 1'b0;
  logic emi_data_write = 1'b0, emi_read_strobe_n = 1'b1, emi_write_strobe_n = 1'b1;
  logic pb_lvl = 1'b0, err;
  logic [6:0] emi_data_out = 7'h00, mem = 7'h00;
  wire [31:0] prdata;
  wire [6:0] emi_data_in, port_f_pin_in, port_f_pin_out, port_f_pin_oe_n, port_f_pin_pullup;
  wire pready, pslverr, port_b_pin_zero_out, port_b_pin_zero_oe_n, port_b_pin_zero_pullup;
  wire read_strobe_n_out, read_strobe_n_oe_n, write_strobe_n_out, write_strobe_n_oe_n;
  // Port B wire: the device wins when it drives
  wire port_b_pin_zero_in = !port_b_pin_zero_oe_n ? port_b_pin_zero_out : pb_lvl;
  int errors = 0;
  int total_checks = 0;

  egpm_pin_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_boot_input, .memory_interface_mode_input,
    .flash_secure_input, .emi_bus_active, .top_address_line, .emi_data_out,
    .emi_data_write, .emi_read_strobe_n, .emi_write_strobe_n, .emi_data_in,
    .port_b_pin_zero_in, .port_b_pin_zero_out, .port_b_pin_zero_oe_n,
    .port_b_pin_zero_pullup, .port_f_pin_in, .port_f_pin_out, .port_f_pin_oe_n,
    .port_f_pin_pullup, .read_strobe_n_out, .read_strobe_n_oe_n, .write_strobe_n_out,
    .write_strobe_n_oe_n);
  egpm_mem_model i_mem (.pclk, .read_strobe_n_out, .read_strobe_n_oe_n, .port_f_pin_out,
    .port_f_pin_oe_n, .port_f_pin_pullup, .mem_word(mem), .port_f_pin_in);

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdata)
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Every strap combination, each through a full reset
  task automatic t_straps;
    logic s;
    for (int i = 0; i < 8; i++) begin
      {external_boot_input, memory_interface_mode_input, flash_secure_input} <= i[2:0];
      do_reset;
      repeat (8) @(posedge pclk);
      s = i[2] | (i[1] & !i[0]);
      rdc(`EGPM_PB_PERIPH_OFF, {31'h0, s}, "strap fn");
      rdc(`EGPM_STATUS_OFF, {30'h0, 1'b1, s}, "status");
    end
  endtask

  // Reset state, and a stray write that must not land
  task automatic t_reset_vals;
    `CHK("f oe", 7'h7f, port_f_pin_oe_n)
    `CHK("f pu", 7'h7f, port_f_pin_pullup)
    `CHK("b pu", 1'b1, port_b_pin_zero_pullup)
    rdc(`EGPM_BUS_CONTROL_OFF, 32'h0, "drive");
    rdc(`EGPM_PF_PERIPH_OFF, 32'h0000fe00, "f per");
    rdc(`EGPM_PF_PULLUP_OFF, 32'h0000fe00, "f pu reg");
    apb(1'b1, 8'h34, 32'h0);
    `CHK("unmapped", 1'b1, err)
    rdc(`EGPM_PB_PERIPH_OFF, 32'h1, "b per kept");
  endtask

  // Port B pin zero as output, then input, then pull-up off
  task automatic t_pb_gpio;
    pb_lvl <= 1'b1;
    apb(1'b1, `EGPM_PB_DATA_OFF, 32'h1);
    apb(1'b1, `EGPM_PB_DIR_OFF, 32'h1);
    apb(1'b1, `EGPM_PB_PERIPH_OFF, 32'h0);
    settle(1);
    `CHK("b oe", 1'b0, port_b_pin_zero_oe_n)
    `CHK("b out", 1'b1, port_b_pin_zero_out)
    apb(1'b1, `EGPM_PB_DIR_OFF, 32'h0);
    settle(4);
    `CHK("b in oe", 1'b1, port_b_pin_zero_oe_n)
    rdc(`EGPM_PB_PIN_OFF, 32'h1, "b pin");
    apb(1'b1, `EGPM_PB_PULLUP_OFF, 32'h0);
    settle(1);
    `CHK("b pu off", 1'b0, port_b_pin_zero_pullup)
  endtask

  // Memory write, memory read, idle floating, idle driven
  task automatic t_bus;
    apb(1'b1, `EGPM_PB_PERIPH_OFF, 32'h1);
    @(posedge pclk);
    emi_bus_active <= 1'b1;
    emi_data_write <= 1'b1;
    emi_data_out <= 7'h55;
    emi_write_strobe_n <= 1'b0;
    top_address_line <= 1'b1;
    settle(1);
    `CHK("wr data", 7'h55, port_f_pin_out)
    `CHK("wr oe", 7'h00, port_f_pin_oe_n)
    `CHK("ws oe", 1'b0, write_strobe_n_oe_n)
    `CHK("ws out", 1'b0, write_strobe_n_out)
    `CHK("addr out", 1'b1, port_b_pin_zero_out)
    @(posedge pclk);
    emi_data_write <= 1'b0;
    emi_write_strobe_n <= 1'b1;
    emi_read_strobe_n <= 1'b0;
    mem <= 7'h2a;
    settle(4);
    `CHK("rd oe", 7'h7f, port_f_pin_oe_n)
    `CHK("rd data", 7'h2a, emi_data_in)
    `CHK("rs out", 1'b0, read_strobe_n_out)
    @(posedge pclk);
    emi_bus_active <= 1'b0;
    emi_read_strobe_n <= 1'b1;
    settle(1);
    `CHK("idle rs", 1'b1, read_strobe_n_oe_n)
    `CHK("idle ws", 1'b1, write_strobe_n_oe_n)
    `CHK("idle addr", 1'b1, port_b_pin_zero_oe_n)
    `CHK("idle data", 7'h7f, port_f_pin_oe_n)
    apb(1'b1, `EGPM_BUS_CONTROL_OFF, 32'h1);
    settle(1);
    `CHK("drv rs", 1'b0, read_strobe_n_oe_n)
    `CHK("drv addr", 1'b0, port_b_pin_zero_oe_n)
    `CHK("drv data", 7'h00, port_f_pin_oe_n)
  endtask

  // Port F pin nine as output, pin fifteen as input, rest on the bus
  task automatic t_pf_gpio;
    apb(1'b1, `EGPM_PF_DATA_OFF, 32'h00000200);
    apb(1'b1, `EGPM_PF_DIR_OFF, 32'h00000200);
    apb(1'b1, `EGPM_PF_PERIPH_OFF, 32'h00007c00);
    settle(1);
    `CHK("f mix oe", 7'h40, port_f_pin_oe_n)
    `CHK("f9 out", 1'b1, port_f_pin_out[0])
    `CHK("f masked", 7'h00, emi_data_in & 7'h41)
    apb(1'b1, `EGPM_PF_PULLUP_OFF, 32'h0000fc00);
    settle(3);
    `CHK("f9 pu off", 7'h7e, port_f_pin_pullup)
    apb(1'b0, `EGPM_PF_PIN_OFF, 32'h0);
    `CHK("f pins", 32'h00008200, rdata & 32'h00008200)
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    t_straps;
    t_reset_vals;
    t_pb_gpio;
    t_bus;
    t_pf_gpio;
    end_of_test;
  end

  // Watchdog; the run needs well under 10 us
  initial begin
    #50us;
    errors++;
    end_of_test;
  end
endmodule
